// ===== rws_pkg.sv
package rws_pkg;

    // =====================================================
    // sequence states
    typedef enum logic [1:0] {
        RWS_RESET = 2'b00,
        RWS_WARMUP = 2'b01,
        RWS_RUN = 2'b10
    } rws_state_t;

    // =====================================================
    // reset sources gathered in one carrier
    typedef struct packed {
        logic power_on;
        logic ext_pin;
        logic internal;
    } rws_sources_t;

    // =====================================================
    // processor start values
    localparam logic [15:0] RWS_VEC_MCU = 16'hFFFE;
    localparam logic [15:0] RWS_VEC_SERIAL = 16'h1FFE;
    localparam logic [15:0] RWS_SP_INIT = 16'h00FF;

    // =====================================================
    // warm-up timing and trimming store
    localparam int RWS_WARMUP_CYCLES = 2048;
    localparam int RWS_CNT_W = 12;
    localparam logic [RWS_CNT_W-1:0] RWS_CNT_ZERO = 12'h000;
    localparam logic [RWS_CNT_W-1:0] RWS_CNT_LAST = 12'(RWS_WARMUP_CYCLES - 1);
    localparam logic [RWS_CNT_W-1:0] RWS_TRIM_ADDR_CYC = 12'h001;
    localparam logic [RWS_CNT_W-1:0] RWS_TRIM_DATA_CYC = 12'h002;
    localparam int RWS_TRIM_W = 8;
    localparam int RWS_TRIM_DEPTH = 4;
    localparam logic [1:0] RWS_TRIM_SLOT = 2'h0;
    localparam logic [RWS_TRIM_W-1:0] RWS_TRIM_ZERO = 8'h00;
    localparam logic [7:0] RWS_BYTE_ZERO = 8'h00;

endpackage : rws_pkg

// ===== rws_trim_store.sv
`timescale 1ns/1ps

// =====================================================
// small non-volatile trimming store model; read data registered
module rws_trim_store
    import rws_pkg::*;
(
    input wire logic core_clk,
    input wire logic [1:0] rd_addr,
    input wire logic rd_en,
    input wire logic [RWS_TRIM_W-1:0] init_data,
    output logic [RWS_TRIM_W-1:0] rd_data
);

    logic [RWS_TRIM_W-1:0] mem [RWS_TRIM_DEPTH];

    // contents are fixed at manufacture; the port stands in for the fuse values
    genvar gi;
    generate
        for (gi = 0; gi < RWS_TRIM_DEPTH; gi++)
        begin : g_word
            assign mem[gi] = init_data ^ RWS_TRIM_W'(gi);
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : rws_trim_store

// ===== rws_sequencer.sv
`timescale 1ns/1ps

// Notes on behaviour
// - power-on, pin and internal resets merge into one request to warm-up logic.
// - while reset is asserted, counter cleared, core and peripherals held in reset.
// - after release, warm-up counter counts high-frequency clock cycles.
// - during warm-up, trimming data read from store and latched for voltage ladder.
// - at warm-up end the core starts from vector at top two addresses, or at 1FFE in serial programming mode.
// - a reset during warm-up clears the counter; counting resumes after release.
// - all sources give same sequence except some registers and voltage detection.
// - register bank select reads zero in reset, warm-up and right after.
// - interrupt master enable, individual enables and latches zero throughout.
// - internal high-frequency oscillator stays enabled throughout.
// - external high- and low-frequency oscillators disabled throughout.
// - prescaler and divider held at zero through reset and warm-up end.
// - only power-on, pin reset or the reset input disables voltage detection.
module rws_sequencer
    import rws_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire rws_sources_t sources,
    input wire logic serial_prog_mode,
    input wire logic [RWS_TRIM_W-1:0] trim_fuse_value,
    output logic core_reset_r,
    output logic periph_reset_r,
    output logic warmup_active_r,
    output logic cpu_run_r,
    output logic [15:0] pc_init_r,
    output logic [15:0] sp_init_r,
    output logic vector_fetch_r,
    output logic [RWS_TRIM_W-1:0] trim_data_r,
    output logic trim_valid_r,
    output logic register_bank_select_r,
    output logic interrupt_master_enable_r,
    output logic individual_interrupt_enables_clr_r,
    output logic interrupt_latches_clr_r,
    output logic int_osc_en_r,
    output logic ext_hf_osc_en_r,
    output logic ext_lf_osc_en_r,
    output logic prescaler_clr_r,
    output logic watchdog_en_r,
    output logic volt_det_disable_r,
    output logic ports_hiz_r
);

    // =====================================================
    // merged request and state
    rws_state_t state_r;
    rws_state_t state_nxt;
    logic [RWS_CNT_W-1:0] cnt_r;
    logic [RWS_CNT_W-1:0] cnt_nxt;
    logic [RWS_TRIM_W-1:0] trim_rd;
    logic rst_req;
    logic hard_src;
    logic cnt_done;
    logic trim_rd_en;
    logic trim_take;
    logic run_start;

    assign rst_req = reset | sources.power_on | sources.ext_pin | sources.internal;
    // internal factors never touch voltage detection
    assign hard_src = reset | sources.power_on | sources.ext_pin;
    assign cnt_done = (state_r == RWS_WARMUP) && (cnt_r == RWS_CNT_LAST);
    assign trim_rd_en = (state_r == RWS_WARMUP) && (cnt_r == RWS_TRIM_ADDR_CYC);
    assign trim_take = (state_r == RWS_WARMUP) && (cnt_r == RWS_TRIM_DATA_CYC);
    assign run_start = cnt_done && !rst_req;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            RWS_RESET:
            begin
                cnt_nxt = RWS_CNT_ZERO;
                if (!rst_req)
                begin
                    state_nxt = RWS_WARMUP;
                end
            end
            RWS_WARMUP:
            begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_done)
                begin
                    state_nxt = RWS_RUN;
                end
            end
            RWS_RUN:
            begin
                cnt_nxt = cnt_r;
            end
            default:
            begin
                state_nxt = RWS_RESET;
                cnt_nxt = RWS_CNT_ZERO;
            end
        endcase
        if (rst_req)
        begin
            state_nxt = RWS_RESET;
            cnt_nxt = RWS_CNT_ZERO;
        end
    end

    always_ff @(posedge core_clk)
    begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
    end

    // =====================================================
    // trimming data fetch
    rws_trim_store u_trim (
        .core_clk(core_clk),
        .rd_addr(RWS_TRIM_SLOT),
        .rd_en(trim_rd_en),
        .init_data(trim_fuse_value),
        .rd_data(trim_rd)
    );

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            trim_data_r <= RWS_TRIM_ZERO;
            trim_valid_r <= 1'b0;
        end
        else if (trim_take)
        begin
            trim_data_r <= trim_rd;
            trim_valid_r <= 1'b1;
        end
    end

    // =====================================================
    // reset states of core, clocks and pins
    always_ff @(posedge core_clk)
    begin
        if (rst_req || state_r != RWS_RUN)
        begin
            core_reset_r <= rst_req || state_r == RWS_RESET;
            periph_reset_r <= rst_req || state_r == RWS_RESET;
            cpu_run_r <= run_start;
            vector_fetch_r <= run_start;
            watchdog_en_r <= run_start;
            register_bank_select_r <= 1'b0;
            interrupt_master_enable_r <= 1'b0;
            individual_interrupt_enables_clr_r <= 1'b1;
            interrupt_latches_clr_r <= 1'b1;
            int_osc_en_r <= 1'b1;
            ext_hf_osc_en_r <= 1'b0;
            ext_lf_osc_en_r <= 1'b0;
            prescaler_clr_r <= 1'b1;
            ports_hiz_r <= 1'b1;
            pc_init_r <= serial_prog_mode ? RWS_VEC_SERIAL : RWS_VEC_MCU;
            sp_init_r <= RWS_SP_INIT;
        end
        else
        begin
            // once running, software owns these; the sequencer just lets go
            core_reset_r <= 1'b0;
            periph_reset_r <= 1'b0;
            cpu_run_r <= 1'b1;
            vector_fetch_r <= 1'b0;
            individual_interrupt_enables_clr_r <= 1'b0;
            interrupt_latches_clr_r <= 1'b0;
            prescaler_clr_r <= 1'b0;
            ports_hiz_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        warmup_active_r <= (state_nxt == RWS_WARMUP);
        if (hard_src)
        begin
            volt_det_disable_r <= 1'b1;
        end
        else if (state_r == RWS_RUN)
        begin
            volt_det_disable_r <= 1'b0;
        end
    end

    // =====================================================
    // checks
    a_req_clears_cnt: assert property (@(posedge core_clk) rst_req |=> cnt_r == RWS_CNT_ZERO)
        else $error("counter not cleared by reset request");
    a_core_held: assert property (@(posedge core_clk) rst_req |=> core_reset_r && periph_reset_r)
        else $error("core not held in reset");
    a_count_steps: assert property (@(posedge core_clk) disable iff (rst_req)
        (state_r == RWS_WARMUP && !cnt_done) |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("warm-up counter did not advance");
    a_run_start: assert property (@(posedge core_clk) run_start |=> cpu_run_r && vector_fetch_r && watchdog_en_r)
        else $error("processor not started at warm-up end");
    a_wdt_off: assert property (@(posedge core_clk) (state_r == RWS_WARMUP && !cnt_done) |=> !watchdog_en_r)
        else $error("watchdog enabled during warm-up");
    a_irq_zero: assert property (@(posedge core_clk) rst_req |=> !interrupt_master_enable_r && interrupt_latches_clr_r)
        else $error("interrupt state not cleared");
    a_osc_state: assert property (@(posedge core_clk) rst_req |=> int_osc_en_r && !ext_hf_osc_en_r && !ext_lf_osc_en_r)
        else $error("oscillator state wrong in reset");
    a_hiz_bank: assert property (@(posedge core_clk) rst_req |=> ports_hiz_r && !register_bank_select_r && prescaler_clr_r)
        else $error("ports, bank or prescaler wrong in reset");
    a_trim_latch: assert property (@(posedge core_clk) disable iff (reset) trim_take |=> trim_valid_r)
        else $error("trimming data not latched");
    a_vd_keep: assert property (@(posedge core_clk) (sources.internal && !hard_src && state_r == RWS_RUN) |=> !volt_det_disable_r)
        else $error("internal reset disabled voltage detection");
    a_pc_vec: assert property (@(posedge core_clk) (rst_req && !serial_prog_mode) |=> pc_init_r == RWS_VEC_MCU)
        else $error("program counter vector wrong");

endmodule : rws_sequencer

// ===== rws_src_model.sv
`timescale 1ns/1ps

// ====
// reset source model: a start pulse raises one source for len cycles (none for kind 3)
module rws_src_model
    import rws_pkg::*;
(
    input wire logic core_clk,
    input wire logic start,
    input wire logic [1:0] kind,
    input wire logic [2:0] len,
    output rws_sources_t sources
);
    logic [2:0] left_r = 3'h0;
    logic [1:0] kind_r = 2'h0;
    always_ff @(posedge core_clk)
    begin
        if (start)
        begin
            left_r <= len;
            kind_r <= kind;
        end
        else if (left_r != 3'h0)
            left_r <= left_r - 3'h1;
    end
    // sources are levels; all low outside a request
    assign sources = (left_r == 3'h0) ? 3'h0 : rws_sources_t'(3'h4 >> kind_r);
endmodule : rws_src_model

// ===== test_reset_warmup_sequencer.sv
`timescale 1ns/1ps

// ====
// bench: random reset requests, each restarted somewhere inside warm-up
module test_reset_warmup_sequencer
    import rws_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset, serial_prog_mode, start;
    logic [RWS_TRIM_W-1:0] trim_fuse_value, trim_data_r;
    logic [1:0] kind;
    logic [2:0] len;
    logic [15:0] pc_init_r, sp_init_r;
    rws_sources_t sources;
    logic core_reset_r, periph_reset_r, warmup_active_r, cpu_run_r, vector_fetch_r, trim_valid_r;
    logic register_bank_select_r, interrupt_master_enable_r, individual_interrupt_enables_clr_r;
    logic interrupt_latches_clr_r, int_osc_en_r, ext_hf_osc_en_r, ext_lf_osc_en_r;
    logic prescaler_clr_r, watchdog_en_r, volt_det_disable_r, ports_hiz_r;
    int err_count = 0;
    int tests_run = 0;
    int seed, n, r, i;
    always #25 core_clk = ~core_clk;
    rws_src_model src (.core_clk(core_clk), .start(start), .kind(kind), .len(len), .sources(sources));
    rws_sequencer dut (
        .core_clk(core_clk), .reset(reset), .sources(sources), .serial_prog_mode(serial_prog_mode),
        .trim_fuse_value(trim_fuse_value), .core_reset_r(core_reset_r),
        .periph_reset_r(periph_reset_r), .warmup_active_r(warmup_active_r), .cpu_run_r(cpu_run_r),
        .pc_init_r(pc_init_r), .sp_init_r(sp_init_r), .vector_fetch_r(vector_fetch_r),
        .trim_data_r(trim_data_r), .trim_valid_r(trim_valid_r),
        .register_bank_select_r(register_bank_select_r),
        .interrupt_master_enable_r(interrupt_master_enable_r),
        .individual_interrupt_enables_clr_r(individual_interrupt_enables_clr_r),
        .interrupt_latches_clr_r(interrupt_latches_clr_r), .int_osc_en_r(int_osc_en_r),
        .ext_hf_osc_en_r(ext_hf_osc_en_r), .ext_lf_osc_en_r(ext_lf_osc_en_r),
        .prescaler_clr_r(prescaler_clr_r), .watchdog_en_r(watchdog_en_r),
        .volt_det_disable_r(volt_det_disable_r), .ports_hiz_r(ports_hiz_r)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic end_sim();
        $display("errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    // ph: 0 in reset, 1 warming up, 2 running
    task automatic chk_phase(input int ph);
        logic h;
        h = (ph < 2);
        if (ph == 0) chk(core_reset_r & periph_reset_r, 1'b1, "core held");
        chk(warmup_active_r, ph == 1, "warm-up flag");
        chk(cpu_run_r, ph == 2, "run flag");
        chk({register_bank_select_r, interrupt_master_enable_r, int_osc_en_r, ext_hf_osc_en_r,
            ext_lf_osc_en_r}, 5'h04, "bank, ime, oscillators");
        chk({individual_interrupt_enables_clr_r, interrupt_latches_clr_r, prescaler_clr_r,
            ports_hiz_r}, {4{h}}, "clears and ports");
        chk({pc_init_r, sp_init_r}, {serial_prog_mode ? RWS_VEC_SERIAL : RWS_VEC_MCU,
            RWS_SP_INIT}, "pc and sp");
        chk(watchdog_en_r, !h, "watchdog");
    endtask : chk_phase
    // counts edges from the first edge without a request until the core runs
    task automatic wait_run();
        n = 0;
        while (sources !== 3'h0 || reset !== 1'b0) @(posedge core_clk) #1;
        while (cpu_run_r !== 1'b1 && n < 3000)
        begin
            @(posedge core_clk);
            #1 n++;
        end
        chk(n >= RWS_WARMUP_CYCLES && n <= RWS_WARMUP_CYCLES + 3, 1'b1, "warm-up length");
        chk(vector_fetch_r, 1'b1, "vector fetch");
        @(posedge core_clk);
        #1 chk({vector_fetch_r, volt_det_disable_r}, 2'h0, "fetch pulse, detector");
        chk_phase(2);
    endtask : wait_run
    task automatic request(input logic [1:0] k, input logic pre);
        @(posedge core_clk);
        #1 start = 1'b1;
        kind = k;
        len = 3'(($random(seed) & 3) + 1);
        @(posedge core_clk);
        #1 start = 1'b0;
        @(posedge core_clk);
        #1 chk_phase(0);
        chk(volt_det_disable_r, pre, "detector by source");
    endtask : request
    initial
    begin
        seed = 34;
        reset = 1'b1;
        start = 1'b0;
        kind = 2'h0;
        len = 3'h1;
        serial_prog_mode = 1'b0;
        trim_fuse_value = RWS_TRIM_ZERO;
        repeat (16) @(posedge core_clk);
        #1 chk_phase(0);
        chk(volt_det_disable_r, 1'b1, "detector off");
        reset = 1'b0;
        wait_run();
        for (i = 0; i < 9; i++)
        begin
            serial_prog_mode = 1'($random(seed));
            trim_fuse_value = 8'($random(seed));
            request(2'(i % 3), (i % 3) != 2);
            // restarts just before the end, just after the start, or at random in the first half
            r = (i == 0) ? 2040 : (i == 1) ? 8 : ($random(seed) & 1023) + 8;
            repeat (r) @(posedge core_clk);
            #1 chk_phase(1);
            chk({trim_valid_r, trim_data_r}, {1'b1, trim_fuse_value ^ 8'(RWS_TRIM_SLOT)}, "trim");
            request(2'(i % 3), (i % 3) != 2);
            wait_run();
        end
        end_sim();
    end
    initial
    begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        end_sim();
    end
endmodule : test_reset_warmup_sequencer
